// File: include/dbgcc_pkg.sv
// Constants shared by the debug comms, vector catch and single step block
`default_nettype none
package dbgcc_pkg;
   // ------------------------------------------------------------------
   // Coprocessor decode
   // ------------------------------------------------------------------
   localparam logic [3:0] DBGCC_CP_NUM      = 4'he;
   localparam logic [3:0] DBGCC_CRN_CTRL    = 4'h0;
   localparam logic [3:0] DBGCC_CRN_DATA    = 4'h1;

   // ------------------------------------------------------------------
   // Debugger scan frame: {rw, addr[4:0], data[31:0]}, lsb shifted first
   // ------------------------------------------------------------------
   localparam int          DBGCC_DATA_W      = 32;
   localparam int          DBGCC_ADDR_W      = 5;
   localparam int          DBGCC_FRAME_W     = 38;
   localparam int          DBGCC_ADDR_LSB    = 32;
   localparam int          DBGCC_RW_BIT      = 37;
   localparam logic [3:0]  DBGCC_CHAIN_DBG   = 4'h2;
   localparam logic [4:0]  DBGCC_A_DBG_CTRL  = 5'h00;
   localparam logic [4:0]  DBGCC_A_VCATCH    = 5'h02;
   localparam logic [4:0]  DBGCC_A_CH_CTRL   = 5'h04;
   localparam logic [4:0]  DBGCC_A_CH_DATA   = 5'h05;

   // ------------------------------------------------------------------
   // Register fields and reset values
   // ------------------------------------------------------------------
   localparam int          DBGCC_DBG_CTRL_W  = 4;
   localparam int          DBGCC_STEP_BIT    = 3;
   localparam int          DBGCC_VCATCH_W    = 8;
   localparam int          DBGCC_VER_LSB     = 28;
   localparam int          DBGCC_W_BIT       = 1;
   localparam int          DBGCC_R_BIT       = 0;
   localparam logic [3:0]  DBGCC_DBG_CTRL_RST = 4'h0;
   localparam logic [7:0]  DBGCC_VCATCH_RST  = 8'h00;
   localparam logic [31:0] DBGCC_VEC_BASE    = 32'h0000_0000;
   localparam int          DBGCC_VEC_SPAN_LSB = 5;

   // ------------------------------------------------------------------
   // Single step sequencer
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      DBGCC_ST_RUN   = 2'b00,
      DBGCC_ST_ARMED = 2'b01,
      DBGCC_ST_TRAP  = 2'b11
   } dbgcc_step_e;
endpackage
`default_nettype wire

// File: include/dbgcc_stream_if.sv
// Valid/ready word stream between the channel logic and its buffer
`default_nettype none
interface dbgcc_stream_if #(parameter int W = 32);
   logic         valid;
   logic         ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// File: rtl/dbgcc_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`default_nettype none
module dbgcc_fifo #(
   parameter int W     = 32,
   parameter int DEPTH = 4
) (
   // Clock and reset
   input  wire logic   sys_clk,
   input  wire logic   rst,
   // Streams
   dbgcc_stream_if.snk in_s,
   dbgcc_stream_if.src out_s
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("dbgcc_fifo: DEPTH must be a power of two, at least 2");
   end
   if (W < 1) begin : g_bad_width
      $error("dbgcc_fifo: W must be positive");
   end

   logic [W-1:0] mem_r [DEPTH];
   logic [AW:0]  wr_ptr_r;
   logic [AW:0]  rd_ptr_r;
   logic         full;
   logic         empty;
   logic         push;
   logic         pop;

   // Extra pointer bit tells full from empty without a counter
   assign empty = (wr_ptr_r == rd_ptr_r);
   assign full  = (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]) && (wr_ptr_r[AW] != rd_ptr_r[AW]);
   assign push  = in_s.valid && !full;
   assign pop   = out_s.ready && !empty;

   assign in_s.ready  = !full;
   assign out_s.valid = !empty;
   assign out_s.data  = mem_r[rd_ptr_r[AW-1:0]];

   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem_r[wr_ptr_r[AW-1:0]] <= in_s.data;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         wr_ptr_r <= '0;
      end else if (push) begin
         wr_ptr_r <= wr_ptr_r + 1'b1;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rd_ptr_r <= '0;
      end else if (pop) begin
         rd_ptr_r <= rd_ptr_r + 1'b1;
      end
   end
endmodule
`default_nettype wire

// File: rtl/dbgcc_top.sv
// Debug comms channel, vector catch and single step logic
`default_nettype none
module dbgcc_top
   import dbgcc_pkg::*;
#(
   parameter int         FIFO_DEPTH = 4,
   parameter logic [3:0] VER_CODE   = 4'h5  // Arbitrary version value
) (
   // Clock and reset
   input  wire logic                      sys_clk,
   input  wire logic                      rst,
   // Core fetch and debug status
   input  wire logic                      fetch_valid,
   input  wire logic [31:0]               fetch_addr,
   input  wire logic                      fetch_exc_entry,
   input  wire logic                      core_in_debug,
   input  wire logic                      instr_exec,
   input  wire logic                      core_cmpct,
   output logic                           breakpoint,
   // Coprocessor register transfers
   input  wire logic                      cp_valid,
   input  wire logic                      cp_read,
   input  wire logic [3:0]                cp_num,
   input  wire logic [3:0]                cp_crn,
   input  wire logic [dbgcc_pkg::DBGCC_DATA_W-1:0] cp_wdata,
   output logic                           cp_ack,
   output logic                           cp_undef,
   output logic [dbgcc_pkg::DBGCC_DATA_W-1:0] cp_rdata,
   // Interrupt indications
   output logic                           channel_rx_indication,
   output logic                           channel_tx_indication,
   // Debugger scan port (asynchronous pins)
   input  wire logic                      dbg_tck,
   input  wire logic                      dbg_tdi,
   input  wire logic                      dbg_shift,
   input  wire logic                      dbg_update,
   input  wire logic [3:0]                dbg_chain,
   output logic                           dbg_tdo
);
   // ------------------------------------------------------------------
   // Pin sampling
   // ------------------------------------------------------------------
   localparam int PIN_W = 8;
   logic [PIN_W-1:0] pin_s1_r;
   logic [PIN_W-1:0] pin_s2_r;
   logic [PIN_W-1:0] pin_s3_r;
   logic [PIN_W-1:0] pin_f_r;
   logic             tck_prev_r;
   logic             tck_rise;
   logic             p_tdi;
   logic             p_shift;
   logic             p_update;
   logic [3:0]       p_chain;

   // A bit counts only once the second and third stages agree
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pin_s1_r <= '0;
         pin_s2_r <= '0;
         pin_s3_r <= '0;
      end else begin
         pin_s1_r <= {dbg_tck, dbg_tdi, dbg_shift, dbg_update, dbg_chain};
         pin_s2_r <= pin_s1_r;
         pin_s3_r <= pin_s2_r;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pin_f_r <= '0;
      end else begin
         pin_f_r <= (pin_s2_r & pin_s3_r) | (pin_f_r & (pin_s2_r | pin_s3_r));
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         tck_prev_r <= 1'b0;
      end else begin
         tck_prev_r <= pin_f_r[7];
      end
   end

   assign tck_rise = pin_f_r[7] && !tck_prev_r;
   assign p_tdi    = pin_f_r[6];
   assign p_shift  = pin_f_r[5];
   assign p_update = pin_f_r[4];
   assign p_chain  = pin_f_r[3:0];

   // ------------------------------------------------------------------
   // Debugger scan frame
   // ------------------------------------------------------------------
   logic [DBGCC_FRAME_W-1:0] frame_r;
   logic                     frame_upd;
   logic                     frame_wr;
   logic [DBGCC_ADDR_W-1:0]  frame_addr;
   logic [DBGCC_DATA_W-1:0]  frame_data;
   logic [DBGCC_DATA_W-1:0]  frame_rd_val;

   // Chain zero never reaches the debug registers
   assign frame_upd  = tck_rise && p_update && (p_chain == DBGCC_CHAIN_DBG);
   assign frame_wr   = frame_r[DBGCC_RW_BIT];
   assign frame_addr = frame_r[DBGCC_ADDR_LSB +: DBGCC_ADDR_W];
   assign frame_data = frame_r[DBGCC_DATA_W-1:0];

   // ------------------------------------------------------------------
   // Debug control and vector catch registers
   // ------------------------------------------------------------------
   logic [DBGCC_DBG_CTRL_W-1:0] dbg_ctrl_r;
   logic [DBGCC_VCATCH_W-1:0]   vcatch_r;

   // The debugger is trusted to write this only while halted
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         dbg_ctrl_r <= DBGCC_DBG_CTRL_RST;
      end else if (frame_upd && frame_wr && frame_addr == DBGCC_A_DBG_CTRL) begin
         dbg_ctrl_r <= frame_data[DBGCC_DBG_CTRL_W-1:0];
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         vcatch_r <= DBGCC_VCATCH_RST;
      end else if (frame_upd && frame_wr && frame_addr == DBGCC_A_VCATCH) begin
         vcatch_r <= frame_data[DBGCC_VCATCH_W-1:0];
      end
   end

   // ------------------------------------------------------------------
   // Channel flags and data
   // ------------------------------------------------------------------
   dbgcc_stream_if #(.W(DBGCC_DATA_W)) in_s ();
   dbgcc_stream_if #(.W(DBGCC_DATA_W)) out_s ();

   logic [DBGCC_DATA_W-1:0] outbound_r;
   logic                    w_flag_r;
   logic                    r_flag;
   logic                    push_pend_r;
   logic [DBGCC_DATA_W-1:0] push_data_r;
   logic                    cp_ok;
   logic                    cp_wr_data;
   logic                    cp_rd_data;
   logic                    dbg_rd_out;
   logic                    dbg_wr_in;

   function automatic logic cp_hit(input logic [3:0] crn, input logic [3:0] want);
      cp_hit = (crn == want);
   endfunction

   // Coprocessor transfers do not exist in the compressed instruction state
   assign cp_ok      = cp_valid && (cp_num == DBGCC_CP_NUM) && !core_cmpct;
   assign cp_wr_data = cp_ok && !cp_read && cp_hit(cp_crn, DBGCC_CRN_DATA);
   assign cp_rd_data = cp_ok && cp_read && cp_hit(cp_crn, DBGCC_CRN_DATA);
   assign dbg_rd_out = frame_upd && !frame_wr && frame_addr == DBGCC_A_CH_DATA;
   assign dbg_wr_in  = frame_upd && frame_wr && frame_addr == DBGCC_A_CH_DATA;
   assign r_flag     = out_s.valid;

   // Core software polls W; an overwrite while full replaces the word
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         outbound_r <= '0;
      end else if (cp_wr_data) begin
         outbound_r <= cp_wdata;
      end
   end

   // Set wins over the debugger's clear in the same cycle
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         w_flag_r <= 1'b0;
      end else if (cp_wr_data) begin
         w_flag_r <= 1'b1;
      end else if (dbg_rd_out) begin
         w_flag_r <= 1'b0;
      end
   end

   // A debugger word waits here until the buffer accepts it
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         push_pend_r <= 1'b0;
      end else if (dbg_wr_in) begin
         push_pend_r <= 1'b1;
      end else if (in_s.ready) begin
         push_pend_r <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         push_data_r <= '0;
      end else if (dbg_wr_in) begin
         push_data_r <= frame_data;
      end
   end

   assign in_s.valid  = push_pend_r;
   assign in_s.data   = push_data_r;
   assign out_s.ready = cp_rd_data;

   dbgcc_fifo #(
      .W     (DBGCC_DATA_W),
      .DEPTH (FIFO_DEPTH)
   ) u_inbound (
      .sys_clk (sys_clk),
      .rst     (rst),
      .in_s    (in_s),
      .out_s   (out_s)
   );

   // ------------------------------------------------------------------
   // Flag synchronisers
   // ------------------------------------------------------------------
   logic [1:0] flag_t1_r;
   logic [1:0] flag_t2_r;
   logic [1:0] flag_c1_r;
   logic [1:0] flag_c2_r;

   // Debugger view advances only on test clock edges
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         flag_t1_r <= '0;
         flag_t2_r <= '0;
      end else if (tck_rise) begin
         flag_t1_r <= {w_flag_r, r_flag};
         flag_t2_r <= flag_t1_r;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         flag_c1_r <= '0;
         flag_c2_r <= '0;
      end else begin
         flag_c1_r <= {w_flag_r, r_flag};
         flag_c2_r <= flag_c1_r;
      end
   end

   function automatic logic [DBGCC_DATA_W-1:0] ctrl_word(input logic [1:0] wr_flags);
      ctrl_word = '0;
      ctrl_word[DBGCC_VER_LSB +: 4] = VER_CODE;
      ctrl_word[DBGCC_W_BIT] = wr_flags[1];
      ctrl_word[DBGCC_R_BIT] = wr_flags[0];
   endfunction

   // ------------------------------------------------------------------
   // Scan shifting and read capture
   // ------------------------------------------------------------------
   always_comb begin
      frame_rd_val = '0;
      if (frame_addr == DBGCC_A_DBG_CTRL) begin
         frame_rd_val[DBGCC_DBG_CTRL_W-1:0] = dbg_ctrl_r;
      end else if (frame_addr == DBGCC_A_VCATCH) begin
         frame_rd_val[DBGCC_VCATCH_W-1:0] = vcatch_r;
      end else if (frame_addr == DBGCC_A_CH_CTRL) begin
         frame_rd_val = ctrl_word(flag_t2_r);
      end else if (frame_addr == DBGCC_A_CH_DATA) begin
         frame_rd_val = outbound_r;
      end
   end

   // A read frame reloads the data field to be shifted out next
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         frame_r <= '0;
      end else if (frame_upd && !frame_wr) begin
         frame_r[DBGCC_DATA_W-1:0] <= frame_rd_val;
      end else if (tck_rise && p_shift && p_chain == DBGCC_CHAIN_DBG) begin
         frame_r <= {p_tdi, frame_r[DBGCC_FRAME_W-1:1]};
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         dbg_tdo <= 1'b0;
      end else begin
         dbg_tdo <= frame_r[0];
      end
   end

   // ------------------------------------------------------------------
   // Coprocessor answers
   // ------------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cp_ack   <= 1'b0;
         cp_undef <= 1'b0;
      end else begin
         cp_ack   <= cp_ok;
         cp_undef <= cp_valid && !cp_ok;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cp_rdata <= '0;
      end else if (cp_ok && cp_read && cp_hit(cp_crn, DBGCC_CRN_CTRL)) begin
         cp_rdata <= ctrl_word(flag_c2_r);
      end else if (cp_rd_data) begin
         cp_rdata <= out_s.data;
      end else if (cp_valid) begin
         cp_rdata <= '0;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         channel_rx_indication <= 1'b0;
         channel_tx_indication <= 1'b0;
      end else begin
         channel_rx_indication <= r_flag;
         channel_tx_indication <= !w_flag_r;
      end
   end

   // ------------------------------------------------------------------
   // Vector catch and single step (own comparators)
   // ------------------------------------------------------------------
   dbgcc_step_e step_r;
   logic        debug_prev_r;
   logic        vec_hit;
   logic        step_hit;

   // Ordinary branches into the vector area carry no exception-entry mark
   assign vec_hit = fetch_valid && fetch_exc_entry
      && fetch_addr[31:DBGCC_VEC_SPAN_LSB] == DBGCC_VEC_BASE[31:DBGCC_VEC_SPAN_LSB]
      && vcatch_r[fetch_addr[DBGCC_VEC_SPAN_LSB-1:2]];
   assign step_hit = (step_r == DBGCC_ST_ARMED) && instr_exec;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         debug_prev_r <= 1'b0;
      end else begin
         debug_prev_r <= core_in_debug;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         step_r <= DBGCC_ST_RUN;
      end else begin
         case (step_r)
            DBGCC_ST_RUN: begin
               if (debug_prev_r && !core_in_debug && dbg_ctrl_r[DBGCC_STEP_BIT]) begin
                  step_r <= DBGCC_ST_ARMED;
               end
            end
            DBGCC_ST_ARMED: begin
               if (step_hit) begin
                  step_r <= DBGCC_ST_TRAP;
               end
            end
            DBGCC_ST_TRAP: begin
               if (core_in_debug) begin
                  step_r <= DBGCC_ST_RUN;
               end
            end
            default: begin
               step_r <= DBGCC_ST_RUN;
            end
         endcase
      end
   end

   // A step trap is held until the core reaches debug, so a stalled core cannot miss it; a vector catch hit is not held
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         breakpoint <= 1'b0;
      end else begin
         breakpoint <= vec_hit || step_hit || (step_r == DBGCC_ST_TRAP && !core_in_debug);
      end
   end
endmodule
`default_nettype wire

// File: bench/dbgcc_top_asserts.sv
// Port-level checker for the debug comms, vector catch and single step block
`default_nettype none
module dbgcc_top_asserts
   import dbgcc_pkg::*;
#(
   parameter logic [3:0] VER_CODE = 4'h5  // Arbitrary version value
) (
   // Clock and reset
   input wire logic                    sys_clk,
   input wire logic                    rst,
   // Core side
   input wire logic                    fetch_valid,
   input wire logic                    fetch_exc_entry,
   input wire logic                    core_in_debug,
   input wire logic                    instr_exec,
   input wire logic                    core_cmpct,
   input wire logic                    breakpoint,
   // Coprocessor port
   input wire logic                    cp_valid,
   input wire logic                    cp_read,
   input wire logic [3:0]              cp_num,
   input wire logic [3:0]              cp_crn,
   input wire logic                    cp_ack,
   input wire logic                    cp_undef,
   input wire logic [DBGCC_DATA_W-1:0] cp_rdata,
   input wire logic                    channel_tx_indication
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking dc @(posedge sys_clk); endclocking
   default disable iff (rst);

   // ---------------------------------------------------------------
   // Transfer sequences
   // ---------------------------------------------------------------
   sequence s_taken;
      cp_valid && cp_num == DBGCC_CP_NUM && !core_cmpct;
   endsequence
   sequence s_ctrl_rd;
      s_taken ##0 (cp_read && cp_crn == DBGCC_CRN_CTRL);
   endsequence
   sequence s_out_wr;
      s_taken ##0 (!cp_read && cp_crn == DBGCC_CRN_DATA);
   endsequence

   property p_ack;
      s_taken |=> cp_ack && !cp_undef;
   endproperty
   a_ack: assert property (p_ack) else $error("accepted transfer not acknowledged");
   property p_undef;
      cp_valid && (core_cmpct || cp_num != DBGCC_CP_NUM) |=> cp_undef && !cp_ack;
   endproperty
   a_undef: assert property (p_undef) else $error("refused transfer not flagged");
   property p_rsp;
      (cp_ack || cp_undef) |-> $past(cp_valid);
   endproperty
   a_rsp: assert property (p_rsp) else $error("response without request");
   property p_ctrl;
      s_ctrl_rd |=> cp_rdata[31:28] == VER_CODE && cp_rdata[27:2] == 26'h0;
   endproperty
   a_ctrl: assert property (p_ctrl) else $error("control word fields wrong");
   property p_wset;
      s_out_wr |=> ##1 !channel_tx_indication;
   endproperty
   a_wset: assert property (p_wset) else $error("outbound write left tx high");
   property p_txfall;
      $fell(channel_tx_indication) |-> $past(cp_valid && !cp_read && !core_cmpct
         && cp_num == DBGCC_CP_NUM && cp_crn == DBGCC_CRN_DATA, 2);
   endproperty
   a_txfall: assert property (p_txfall) else $error("tx fell without a write");
   property p_bpcause;
      $rose(breakpoint) |-> $past(fetch_valid && fetch_exc_entry) || $past(instr_exec);
   endproperty
   a_bpcause: assert property (p_bpcause) else $error("breakpoint without cause");
   property p_step;
      breakpoint && !core_in_debug && !$past(fetch_valid && fetch_exc_entry) |=> breakpoint;
   endproperty
   a_step: assert property (p_step) else $error("step trap dropped early");
endmodule

bind dbgcc_top dbgcc_top_asserts #(.VER_CODE(VER_CODE)) chk_u (
   .sys_clk(sys_clk), .rst(rst), .fetch_valid(fetch_valid),
   .fetch_exc_entry(fetch_exc_entry), .core_in_debug(core_in_debug),
   .instr_exec(instr_exec), .core_cmpct(core_cmpct), .breakpoint(breakpoint),
   .cp_valid(cp_valid), .cp_read(cp_read), .cp_num(cp_num), .cp_crn(cp_crn),
   .cp_ack(cp_ack), .cp_undef(cp_undef), .cp_rdata(cp_rdata),
   .channel_tx_indication(channel_tx_indication));
`default_nettype wire

// File: bench/dbgcc_dbg_model.sv
// Debugger model driving the scan pins of the comms block
`default_nettype none
module dbgcc_dbg_model
   import dbgcc_pkg::*;
(
   // Scan pins
   output logic       dbg_tck,
   output logic       dbg_tdi,
   output logic       dbg_shift,
   output logic       dbg_update,
   output logic [3:0] dbg_chain,
   input  wire logic  dbg_tdo
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      dbg_tck = 1'b0;
      dbg_tdi = 1'b0;
      dbg_shift = 1'b0;
      dbg_update = 1'b0;
      dbg_chain = 4'h2;
   end
   // ---------------------------------------------------------------
   // Frames; the test clock stands still between them
   // ---------------------------------------------------------------
   task automatic tick(input logic s, input logic u, input logic d, output logic o);
      dbg_shift = s;
      dbg_update = u;
      dbg_tdi = d;
      #200;
      o = dbg_tdo;
      dbg_tck = 1'b1;
      #200;
      dbg_tck = 1'b0;
   endtask
   task automatic xfer(input logic [3:0] ch, input logic [37:0] f, output logic [31:0] q);
      logic o;
      dbg_chain = ch;
      for (int i = 0; i < 38; i++) tick(1'b1, 1'b0, f[i], o);
      tick(1'b0, 1'b1, ~dbg_tdi, o);
      for (int i = 0; i < 32; i++) tick(1'b1, 1'b0, ~dbg_tdi, q[i]);
      dbg_shift = 1'b0;
      dbg_tdi = ~dbg_tdi;
   endtask
   // Inbound words wait, for up to 8 polls of R, until the processor has taken the last one
   task automatic send(input logic [3:0] ch, input logic [4:0] a, input logic [31:0] d);
      logic [31:0] q;
      for (int i = 0; i < 8 && a == DBGCC_A_CH_DATA; i++) begin
         xfer(4'h2, {1'b0, DBGCC_A_CH_CTRL, 32'h0}, q);
         if (q[0] === 1'b0) break;
      end
      xfer(ch, {1'b1, a, d}, q);
   endtask
endmodule
`default_nettype wire

// File: bench/dbgcc_top_tb_top.sv
// Self-checking bench for the debug comms, vector catch and single step block
`default_nettype none
module dbgcc_top_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import dbgcc_pkg::*;
   localparam logic [3:0] VER = 4'h5;  // Arbitrary version value
   logic        sys_clk, rst, fetch_valid, fetch_exc_entry, core_in_debug, instr_exec;
   logic        core_cmpct, breakpoint, cp_valid, cp_read, cp_ack, cp_undef;
   logic        channel_rx_indication, channel_tx_indication;
   logic        dbg_tck, dbg_tdi, dbg_shift, dbg_update, dbg_tdo;
   logic [3:0]  cp_num, cp_crn, dbg_chain;
   logic [31:0] fetch_addr, cp_wdata, cp_rdata, q;
   int          mismatches, checked, cycles;

   dbgcc_top #(.FIFO_DEPTH(4), .VER_CODE(VER)) dut_u (
      .sys_clk(sys_clk), .rst(rst), .fetch_valid(fetch_valid), .fetch_addr(fetch_addr),
      .fetch_exc_entry(fetch_exc_entry), .core_in_debug(core_in_debug),
      .instr_exec(instr_exec), .core_cmpct(core_cmpct), .breakpoint(breakpoint),
      .cp_valid(cp_valid), .cp_read(cp_read), .cp_num(cp_num), .cp_crn(cp_crn),
      .cp_wdata(cp_wdata), .cp_ack(cp_ack), .cp_undef(cp_undef), .cp_rdata(cp_rdata),
      .channel_rx_indication(channel_rx_indication),
      .channel_tx_indication(channel_tx_indication), .dbg_tck(dbg_tck), .dbg_tdi(dbg_tdi),
      .dbg_shift(dbg_shift), .dbg_update(dbg_update), .dbg_chain(dbg_chain),
      .dbg_tdo(dbg_tdo));
   dbgcc_dbg_model model_u (.dbg_tck(dbg_tck), .dbg_tdi(dbg_tdi), .dbg_shift(dbg_shift),
      .dbg_update(dbg_update), .dbg_chain(dbg_chain), .dbg_tdo(dbg_tdo));
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         summarize();
      end
   end
   // ---------------------------------------------------------------
   // Helpers; inputs move 2 ns after the rising edge
   // ---------------------------------------------------------------
   task automatic summarize;
      $display("mismatches %0d, checked %0d", mismatches, checked);
      if (mismatches == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t ns: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge sys_clk);
      #2;
   endtask
   task automatic cp(input logic rd, input logic th, input logic [3:0] num,
                     input logic [3:0] crn, input logic [31:0] wd, input logic ea,
                     output logic [31:0] rq);
      idle(1);
      cp_valid = 1'b1;
      cp_read = rd;
      cp_num = num;
      cp_crn = crn;
      cp_wdata = wd;
      core_cmpct = th;
      idle(1);
      cp_valid = 1'b0;
      core_cmpct = 1'b0;
      chk({cp_ack, cp_undef}, {ea, ~ea});
      rq = cp_rdata;
   endtask
   task automatic fetch(input logic [31:0] a, input logic exc, input logic bp);
      idle(1);
      fetch_valid = 1'b1;
      fetch_addr = a;
      fetch_exc_entry = exc;
      idle(1);
      fetch_valid = 1'b0;
      chk(breakpoint, bp);
   endtask
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_ctrl;
      cp(1'b0, 1'b0, DBGCC_CP_NUM, DBGCC_CRN_CTRL, 32'hffff_ffff, 1'b1, q);
      cp(1'b1, 1'b0, DBGCC_CP_NUM, DBGCC_CRN_CTRL, 32'h0, 1'b1, q);
      chk(q, {VER, 28'h0});
   endtask
   task automatic t_send;
      cp(1'b0, 1'b0, DBGCC_CP_NUM, DBGCC_CRN_DATA, 32'hc0de_5a17, 1'b1, q);
      idle(1);
      chk(channel_tx_indication, 1'b0);
      idle(4);
      cp(1'b1, 1'b0, DBGCC_CP_NUM, DBGCC_CRN_CTRL, 32'h0, 1'b1, q);
      chk(q[1:0], 2'b10);
      model_u.xfer(4'h2, {1'b0, DBGCC_A_CH_CTRL, 32'h0}, q);
      chk(q[1:0], 2'b10);
      model_u.xfer(4'h2, {1'b0, DBGCC_A_CH_DATA, 32'h0}, q);
      chk(q, 32'hc0de_5a17);
      idle(8);
      chk(channel_tx_indication, 1'b1);
   endtask
   task automatic t_recv;
      model_u.send(4'h2, DBGCC_A_CH_DATA, 32'h1234_abcd);
      idle(8);
      chk(channel_rx_indication, 1'b1);
      cp(1'b1, 1'b0, DBGCC_CP_NUM, DBGCC_CRN_CTRL, 32'h0, 1'b1, q);
      chk(q[1:0], 2'b01);
      cp(1'b1, 1'b0, DBGCC_CP_NUM, DBGCC_CRN_DATA, 32'h0, 1'b1, q);
      chk(q, 32'h1234_abcd);
      idle(1);
      chk(channel_rx_indication, 1'b0);
   endtask
   task automatic t_refuse;
      cp(1'b0, 1'b1, DBGCC_CP_NUM, DBGCC_CRN_DATA, 32'h5555_aaaa, 1'b0, q);
      cp(1'b1, 1'b0, 4'h7, DBGCC_CRN_CTRL, 32'h0, 1'b0, q);
      idle(2);
      chk(channel_tx_indication, 1'b1);
      model_u.send(4'h0, DBGCC_A_CH_DATA, 32'h0bad_0bad);
      idle(8);
      chk(channel_rx_indication, 1'b0);
   endtask
   task automatic t_vcatch;
      model_u.send(4'h2, DBGCC_A_VCATCH, 32'h0000_0004);
      fetch(32'h0000_0008, 1'b1, 1'b1);
      fetch(32'h0000_0008, 1'b0, 1'b0);
      fetch(32'h0000_0004, 1'b1, 1'b0);
   endtask
   task automatic t_step;
      core_in_debug = 1'b1;
      model_u.send(4'h2, DBGCC_A_DBG_CTRL, 32'h0000_0008);
      idle(1);
      core_in_debug = 1'b0;
      idle(3);
      chk(breakpoint, 1'b0);
      instr_exec = 1'b1;
      idle(1);
      instr_exec = 1'b0;
      chk(breakpoint, 1'b1);
      idle(4);
      chk(breakpoint, 1'b1);
      core_in_debug = 1'b1;
      idle(2);
      chk(breakpoint, 1'b0);
      model_u.send(4'h2, DBGCC_A_DBG_CTRL, 32'h0);
   endtask
   initial begin
      rst = 1'b1;
      {fetch_valid, fetch_exc_entry, core_in_debug, instr_exec, core_cmpct} = 5'h00;
      {cp_valid, cp_read, cp_num, cp_crn, cp_wdata, fetch_addr} = 74'h0;
      repeat (12) @(posedge sys_clk);
      #2;
      rst = 1'b0;
      idle(2);
      chk({cp_ack, cp_undef, breakpoint, channel_rx_indication, channel_tx_indication},
          5'h01);
      t_ctrl();
      t_send();
      t_recv();
      t_refuse();
      t_vcatch();
      t_step();
      summarize();
   end
endmodule
`default_nettype wire
